// ---- hdl/host_port_pkg.sv ----
// Shared constants and types for the parallel host port
`default_nettype none
package host_port_pkg;
    localparam int DATA_W = 8;
    // Bus style selected by interface_family_pick
    localparam logic FAMILY_8080 = 1'b0;
    localparam logic FAMILY_6800 = 1'b1;
    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] ACC_RST = 4'h0;
    // Access kind, one-hot
    typedef enum logic [3:0] {
        ACC_STATUS_RD = 4'h1,
        ACC_DATA_RD = 4'h2,
        ACC_DATA_WR = 4'h4,
        ACC_CMD_WR = 4'h8
    } access_t;
    // Access phase state of the port top, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h4
    } port_state_t;
endpackage
`default_nettype wire

// ---- hdl/access_bus_if.sv ----
// Interface carrying the decoded access between decoder and port top
`default_nettype none
interface access_bus_if;
    logic rd_active;
    logic wr_active;
    logic rd_status;
    logic wr_command;
    modport decoder (output rd_active, output wr_active, output rd_status, output wr_command);
    modport user (input rd_active, input wr_active, input rd_status, input wr_command);
endinterface
`default_nettype wire

// ---- hdl/bus_style_decoder.sv ----
// Combinational decode of 8080 or 6800 style strobes into access phases
`default_nettype none
module bus_style_decoder
    import host_port_pkg::*;
(
    // Pin levels, already in clk domain
    input wire logic family,
    input wire logic chip_select_n,
    input wire logic strobe_a,
    input wire logic strobe_b,
    input wire logic command_data_select,
    // Decoded access
    access_bus_if.decoder acc
);
    // Chip select gates both access phases, not the select decode; in 6800 mode enable high is the active phase
    always_comb begin
        acc.rd_active = 1'b0;
        acc.wr_active = 1'b0;
        if (!chip_select_n) begin
            if (family == FAMILY_8080) begin
                acc.rd_active = !strobe_a && strobe_b;
                acc.wr_active = strobe_a && !strobe_b;
            end else begin
                acc.rd_active = strobe_a && strobe_b;
                acc.wr_active = strobe_a && !strobe_b;
            end
        end
        // Status read on select 0; command write on select 1
        acc.rd_status = !command_data_select;
        acc.wr_command = command_data_select;
    end
endmodule
`default_nettype wire

// ---- hdl/mcu_parallel_host_port.sv ----
// Parallel host port of a dot-matrix LCD controller
// Functional notes
// - In 8080 mode the write strobe is active low and only its low pulse is a write.
// - In 8080 mode the data byte is captured at the rising edge of the write strobe.
// - In 6800 mode the read/write level high means read and low means write.
// - In 6800 mode transfers happen only while the enable clock is high.
// - The port responds only while the active-low chip select is asserted.
// - 8080 reads return status on select 0 and display data or cursor address on select 1.
// - 8080 writes take data or a parameter on select 0 and a command on select 1.
// - 6800 accesses with enable high decode read/write and select in the same way.
// - Driving the active-low hardware clear input low resets the port.
// - A strapped select picks 8080 strobes when low and 6800 signalling when high.
`default_nettype none
module mcu_parallel_host_port
    import host_port_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic hardware_clear_n,
    // Bus style strap
    input wire logic interface_family_pick,
    // Processor bus pins
    input wire logic chip_select_n,
    input wire logic rd_n_or_enable,
    input wire logic wr_n_or_rw,
    input wire logic command_data_select,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Read sources from the controller core
    input wire logic [7:0] status_flags,
    input wire logic [7:0] read_data,
    // Write and read results to the controller core
    output logic [7:0] write_byte,
    output logic write_is_command,
    output logic write_valid,
    output logic read_is_data,
    output logic read_done
);
    logic family_reg;
    logic strap_taken_reg;
    logic wr_prev_reg;
    logic rd_prev_reg;
    logic [7:0] data_in_reg;
    logic cmd_reg;
    port_state_t state_reg;
    logic [7:0] data_out_reg;
    logic data_oe_reg;
    logic [7:0] write_byte_reg;
    logic write_is_command_reg;
    logic write_valid_reg;
    logic read_is_data_reg;
    logic read_done_reg;
    logic clear;
    access_bus_if acc();

    // Hardware clear acts as a synchronous reset beside the async one
    assign clear = !hardware_clear_n;

    bus_style_decoder bus_style_decoder_i (
        .family(family_reg),
        .chip_select_n(chip_select_n),
        .strobe_a(rd_n_or_enable),
        .strobe_b(wr_n_or_rw),
        .command_data_select(command_data_select),
        .acc(acc)
    );

    // Strap taken once after reset release; tied pin so no later change is expected
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            family_reg <= FAMILY_8080;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            family_reg <= interface_family_pick;
            strap_taken_reg <= 1'b1;
        end
    end

    // Keep the last bus byte and select while a write is active, so the byte
    // present just before the strobe rises is the one committed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_in_reg <= DATA_RST;
            cmd_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            rd_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= acc.wr_active;
            rd_prev_reg <= acc.rd_active;
            if (acc.wr_active) begin
                data_in_reg <= data_in;
                cmd_reg <= acc.wr_command;
            end
        end
    end

    // Access state: idle, read phase, write phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else if (clear) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (acc.rd_active) begin
                        state_reg <= ST_READ;
                    end else if (acc.wr_active) begin
                        state_reg <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (!acc.rd_active) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (!acc.wr_active) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Commit write at the end of the write phase (strobe rise or enable fall)
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_byte_reg <= DATA_RST;
            write_is_command_reg <= 1'b0;
            write_valid_reg <= 1'b0;
        end else if (clear) begin
            write_byte_reg <= DATA_RST;
            write_is_command_reg <= 1'b0;
            write_valid_reg <= 1'b0;
        end else begin
            write_valid_reg <= wr_prev_reg && !acc.wr_active;
            if (wr_prev_reg && !acc.wr_active) begin
                write_byte_reg <= data_in_reg;
                write_is_command_reg <= cmd_reg;
            end
        end
    end

    // Read drive: one cycle latency from strobe to data on pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_out_reg <= DATA_RST;
            data_oe_reg <= 1'b0;
            read_is_data_reg <= 1'b0;
            read_done_reg <= 1'b0;
        end else if (clear) begin
            data_out_reg <= DATA_RST;
            data_oe_reg <= 1'b0;
            read_is_data_reg <= 1'b0;
            read_done_reg <= 1'b0;
        end else begin
            data_oe_reg <= acc.rd_active;
            read_done_reg <= rd_prev_reg && !acc.rd_active;
            if (acc.rd_active) begin
                data_out_reg <= acc.rd_status ? status_flags : read_data;
                read_is_data_reg <= !acc.rd_status;
            end
        end
    end

    assign data_out = data_out_reg;
    assign data_oe = data_oe_reg;
    assign write_byte = write_byte_reg;
    assign write_is_command = write_is_command_reg;
    assign write_valid = write_valid_reg;
    assign read_is_data = read_is_data_reg;
    assign read_done = read_done_reg;

    // Checks
    chk_oe_needs_read: assert property (@(posedge clk) disable iff (reset)
        data_oe |-> $past(acc.rd_active)) else $error("data driven without read");
    chk_cs_gates_oe: assert property (@(posedge clk) disable iff (reset)
        $past(chip_select_n) && !$past(clear) |-> !data_oe) else $error("drive while deselected");
    chk_write_at_end: assert property (@(posedge clk) disable iff (reset || clear)
        $fell(acc.wr_active) |=> write_valid) else $error("write not committed at strobe end");
    chk_write_byte_val: assert property (@(posedge clk) disable iff (reset)
        write_valid |-> write_byte == $past(data_in_reg)) else $error("wrong write byte");
    chk_write_kind: assert property (@(posedge clk) disable iff (reset)
        write_valid |-> write_is_command == $past(cmd_reg)) else $error("wrong write kind");
    chk_status_read: assert property (@(posedge clk) disable iff (reset || clear)
        acc.rd_active && !command_data_select |=> data_out == $past(status_flags))
        else $error("status not returned");
    chk_data_read: assert property (@(posedge clk) disable iff (reset || clear)
        acc.rd_active && command_data_select |=> data_out == $past(read_data))
        else $error("read data not returned");
    chk_6800_low_e: assert property (@(posedge clk) disable iff (reset)
        family_reg && !rd_n_or_enable |-> !acc.rd_active && !acc.wr_active)
        else $error("6800 access with enable low");
    chk_8080_wr_low: assert property (@(posedge clk) disable iff (reset)
        !family_reg && acc.wr_active |-> !wr_n_or_rw) else $error("8080 write without low strobe");
    chk_6800_dir: assert property (@(posedge clk) disable iff (reset)
        family_reg && acc.rd_active |-> wr_n_or_rw) else $error("6800 read with rw low");
    chk_clear_idle: assert property (@(posedge clk) disable iff (reset)
        clear |=> !write_valid && !data_oe) else $error("clear did not reset outputs");
    chk_strap_once: assert property (@(posedge clk) disable iff (reset)
        strap_taken_reg |=> $stable(family_reg)) else $error("family changed after strap");
    // Phase tracker must agree with chip select and with the edge detectors that commit reads and writes
    chk_phase_cs: assert property (@(posedge clk) disable iff (reset)
        state_reg != ST_IDLE |-> !$past(chip_select_n))
        else $error("access phase while deselected");
    chk_phase_write: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_WRITE |-> wr_prev_reg) else $error("write phase without write");
    chk_phase_read: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_READ |-> rd_prev_reg) else $error("read phase without read");

    cov_cmd_write: cover property (@(posedge clk) write_valid && write_is_command);
    cov_data_write: cover property (@(posedge clk) write_valid && !write_is_command);
    cov_status_read: cover property (@(posedge clk) data_oe && !read_is_data);
    cov_6800_read: cover property (@(posedge clk) family_reg && read_done);
endmodule
`default_nettype wire

// ---- test/host_cpu_model.sv ----
// Behavioural processor driving the parallel host port pins
`default_nettype none
module host_cpu_model
    import host_port_pkg::*;
(
    // Clock and strap
    input wire logic clk,
    input wire logic interface_family_pick,
    // Bus pins toward the port
    output logic chip_select_n,
    output logic rd_n_or_enable,
    output logic wr_n_or_rw,
    output logic command_data_select,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        chip_select_n = 1'b1;
        rd_n_or_enable = 1'b1;
        wr_n_or_rw = 1'b1;
        command_data_select = 1'b0;
        data_in = 8'h00;
    end

    // Idle levels; select and data lines flip so a late capture cannot match by luck
    task automatic release_bus();
        chip_select_n <= 1'b1;
        rd_n_or_enable <= (interface_family_pick == FAMILY_6800) ? 1'b0 : 1'b1;
        wr_n_or_rw <= 1'b1;
        command_data_select <= ~command_data_select;
        data_in <= ~data_in;
    endtask

    // One access; good low breaks the strobe pattern so the port must ignore it
    task automatic xfer(input logic is_wr, input logic sel, input logic [7:0] d,
                        input logic cs_n, input logic good, input int hold);
        @(posedge clk);
        chip_select_n <= cs_n;
        command_data_select <= sel;
        data_in <= is_wr ? d : ~data_in;
        if (interface_family_pick == FAMILY_8080) begin
            rd_n_or_enable <= good ? is_wr : 1'b0;
            wr_n_or_rw <= good ? ~is_wr : 1'b0;
        end else begin
            rd_n_or_enable <= good;
            wr_n_or_rw <= ~is_wr;
        end
        repeat (hold) @(posedge clk);
        release_bus();
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- test/mcu_parallel_host_port_tb.sv ----
// Self-checking bench for the parallel host port
`default_nettype none
module mcu_parallel_host_port_tb
    import host_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset, hardware_clear_n, interface_family_pick;
    logic [7:0] status_flags, read_data, exp_rd;
    wire logic chip_select_n, rd_n_or_enable, wr_n_or_rw, command_data_select;
    wire logic [7:0] data_in;
    logic [7:0] data_out, write_byte;
    logic data_oe, write_is_command, write_valid, read_is_data, read_done;
    int n_mismatch = 0, checks_done = 0, seed = 22, n_wv = 0, n_rd = 0, n_oe = 0, cyc = 0;

    mcu_parallel_host_port mcu_parallel_host_port_i (.clk(clk), .reset(reset),
        .hardware_clear_n(hardware_clear_n), .interface_family_pick(interface_family_pick),
        .chip_select_n(chip_select_n), .rd_n_or_enable(rd_n_or_enable),
        .wr_n_or_rw(wr_n_or_rw), .command_data_select(command_data_select),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .status_flags(status_flags), .read_data(read_data), .write_byte(write_byte),
        .write_is_command(write_is_command), .write_valid(write_valid),
        .read_is_data(read_is_data), .read_done(read_done));
    host_cpu_model host_cpu_model_i (.clk(clk), .interface_family_pick(interface_family_pick),
        .chip_select_n(chip_select_n), .rd_n_or_enable(rd_n_or_enable),
        .wr_n_or_rw(wr_n_or_rw), .command_data_select(command_data_select),
        .data_in(data_in));

    always #2.5 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected read byte: select 0 returns status, select 1 returns display data
    function automatic logic [7:0] pick_read(input logic sel, input logic [7:0] s, r);
        return sel ? r : s;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Pulse counters and cycle ceiling; a hang ends in the report
    always @(posedge clk) begin
        cyc++;
        if (write_valid === 1'b1) n_wv++;
        if (read_done === 1'b1) n_rd++;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Read byte is checked in the middle of every driven cycle
    always @(negedge clk) begin
        if (data_oe === 1'b1) begin
            n_oe++;
            check("read byte", data_out, exp_rd);
        end
    end

    task automatic do_reset(input logic fam);
        @(posedge clk);
        reset <= 1'b1;
        interface_family_pick <= fam;
        repeat (10) @(posedge clk);
        host_cpu_model_i.release_bus();
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("oe after reset", {7'h00, data_oe}, 8'h00);
    endtask

    task automatic op(input logic is_wr, input logic sel, input logic cs_n, input logic good);
        int w0, r0, o0;
        logic [7:0] d, s, r;
        logic take;
        d = 8'($random(seed));
        s = 8'($random(seed));
        r = 8'($random(seed));
        take = good & ~cs_n;
        exp_rd = pick_read(sel, s, r);
        @(posedge clk);
        status_flags <= s;
        read_data <= r;
        w0 = n_wv;
        r0 = n_rd;
        o0 = n_oe;
        host_cpu_model_i.xfer(is_wr, sel, d, cs_n, good, 2);
        repeat (3) @(posedge clk);
        #1;
        check("write pulses", 8'(n_wv - w0), {7'h00, take & is_wr});
        check("read pulses", 8'(n_rd - r0), {7'h00, take & ~is_wr});
        check("bus drive", {7'h00, n_oe != o0}, {7'h00, take & ~is_wr});
        check("bus released", {7'h00, data_oe}, 8'h00);
        if (take & is_wr) begin
            check("write byte", write_byte, d);
            check("command flag", {7'h00, write_is_command}, {7'h00, sel});
        end
        if (take & ~is_wr)
            check("read kind", {7'h00, read_is_data}, {7'h00, sel});
    endtask

    // Both bus styles: corner cases, random traffic, then a hardware clear
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        hardware_clear_n = 1'b1;
        interface_family_pick = FAMILY_8080;
        status_flags = 8'h00;
        read_data = 8'h00;
        exp_rd = 8'h00;
        for (int f = 0; f < 2; f++) begin
            do_reset(f[0]);
            op(1'b0, 1'b0, 1'b1, 1'b1);
            op(1'b1, 1'b0, 1'b1, 1'b1);
            op(1'b1, 1'b1, 1'b0, 1'b0);
            op(1'b0, 1'b1, 1'b0, 1'b0);
            repeat (16) op(1'($random(seed)), 1'($random(seed)), 1'b0, 1'b1);
            op(1'b1, 1'b1, 1'b0, 1'b1);
            @(posedge clk);
            hardware_clear_n <= 1'b0;
            repeat (2) @(posedge clk);
            hardware_clear_n <= 1'b1;
            @(posedge clk);
            #1 check("cleared byte", write_byte, 8'h00);
            check("cleared flag", {7'h00, write_is_command}, 8'h00);
            op(1'b1, 1'b0, 1'b0, 1'b1);
        end
        summarize();
    end
endmodule
`default_nettype wire
